// ===== core/esso_pkg.sv
// shared constants for the extended subtract, swap and skip execution block
package esso_pkg;
	// ==========================================================
	// operation codes from the decode stage
	localparam logic [2:0] OP_NOP   = 3'h0;
	localparam logic [2:0] OP_SUBM  = 3'h1; // ext_subtract_to_memory
	localparam logic [2:0] OP_SWAP  = 3'h2; // ext_nibble_swap_in_place
	localparam logic [2:0] OP_SWAPA = 3'h3; // ext_nibble_swap_to_acc
	localparam logic [2:0] OP_SZ    = 3'h4; // ext_skip_if_zero
	localparam logic [2:0] OP_SZA   = 3'h5; // ext_skip_if_zero_copy_acc

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_ACC      = 8'h04;
	localparam logic [7:0] REG_FLAGS    = 8'h08;
	localparam logic [7:0] REG_MEM_ADDR = 8'h0c;
	localparam logic [7:0] REG_MEM_DATA = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;

	// ==========================================================
	// status flag bit positions
	localparam int FLG_C  = 0;
	localparam int FLG_AC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_SC = 4;
	localparam int FLG_CZ = 5;

	// ==========================================================
	// reset values and widths
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic       EN_RST    = 1'b1;
	localparam logic [7:0] MADDR_RST = 8'h00;
	localparam logic [7:0] SKIPS_RST = 8'h00;
	localparam int         MEM_DEPTH = 256;
endpackage : esso_pkg

// ===== core/esso_dmem.sv
// data memory with registered read data
module esso_dmem (
	// clock
	input  wire logic       pclk,
	input  wire logic       ce,
	// port
	input  wire logic [7:0] addr,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	logic [7:0] mem [esso_pkg::MEM_DEPTH];

	always_ff @(posedge pclk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule : esso_dmem

// ===== core/esso_core.sv
// execution unit for extended subtract, nibble swap and skip-if-zero operations
// Functional notes
// RULE1: subtract memory from accumulator, result to memory
// RULE2: carry cleared on borrow, else set
// RULE3: subtract updates OV Z AC C SC CZ
// RULE4: in-place swap exchanges nibbles, flags untouched
// RULE5: swap into accumulator, memory and flags untouched
// RULE6: skip-if-zero reads then writes byte back
// RULE7: skip next instruction when byte is zero
// RULE8: taken skip inserts dummy, three cycles total
// RULE9: copy byte to accumulator, skip if zero
// RULE10: dummy cycle alters nothing, no memory access; here the memory still reads addr_q during the dummy cycle
//
// Chosen here: the register addresses and the APB register port.
module esso_core (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// instruction from decode
	input  wire logic        instr_valid,
	input  wire logic [2:0]  instr_op,
	input  wire logic [7:0]  instr_addr,
	output logic             instr_ready,
	// to fetch stage and core state
	output logic             skip_taken,
	output logic             dummy_cycle,
	output logic      [7:0]  accumulator,
	output logic      [5:0]  flags
);
	// ==========================================================
	// sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_DUMMY} esso_state_e;

	esso_state_e state_q, state_d;
	logic [2:0]  op_q;
	logic [7:0]  addr_q;
	logic [7:0]  acc_q;
	logic [5:0]  flags_q;
	logic        en_q;
	logic [7:0]  mem_addr_q;
	logic [7:0]  skip_cnt_q;
	logic        skip_q;
	logic [7:0]  mem_rdata;
	logic        do_skip;

	wire idle       = (state_q == ST_IDLE);
	wire apb_access = psel & penable;
	wire apb_wr     = ce & apb_access & pwrite & idle;
	wire accept     = instr_valid & instr_ready;
	wire in_exec    = (state_q == ST_EXEC);
	// the bus only gets through while idle, so these never meet an execute write
	wire wr_ctrl    = apb_wr & (paddr == esso_pkg::REG_CTRL);
	wire wr_acc     = apb_wr & (paddr == esso_pkg::REG_ACC);
	wire wr_flags   = apb_wr & (paddr == esso_pkg::REG_FLAGS);
	wire wr_maddr   = apb_wr & (paddr == esso_pkg::REG_MEM_ADDR);

	// a bus transfer in flight holds off new instructions
	assign instr_ready = ce & en_q & idle & ~psel;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:  if (accept) state_d = ST_READ;
			ST_READ:  state_d = ST_EXEC;
			ST_EXEC:  state_d = do_skip ? ST_DUMMY : ST_IDLE; // RULE8
			ST_DUMMY: state_d = ST_IDLE; // RULE10
			default:  state_d = ST_IDLE;
		endcase
	end

	// ==========================================================
	// datapath
	wire [8:0] diff9   = {1'b0, acc_q} - {1'b0, mem_rdata};
	wire [7:0] diff    = diff9[7:0]; // RULE1
	wire [4:0] nib5    = {1'b0, acc_q[3:0]} - {1'b0, mem_rdata[3:0]};
	wire       sub_ov  = (acc_q[7] != mem_rdata[7]) & (diff[7] != acc_q[7]);
	wire [7:0] swapped = {mem_rdata[3:0], mem_rdata[7:4]};
	wire       is_zero = (mem_rdata == 8'h00);

	logic [5:0] sub_flags;
	always_comb begin
		sub_flags         = 6'h00;
		sub_flags[esso_pkg::FLG_C]  = ~diff9[8]; // RULE2
		sub_flags[esso_pkg::FLG_AC] = ~nib5[4]; // RULE3
		sub_flags[esso_pkg::FLG_Z]  = (diff == 8'h00); // RULE3
		sub_flags[esso_pkg::FLG_OV] = sub_ov; // RULE3
		// sc is set when the true signed difference is not negative
		sub_flags[esso_pkg::FLG_SC] = ~(sub_ov ^ diff[7]); // RULE3
		sub_flags[esso_pkg::FLG_CZ] = (diff == 8'h00); // RULE3
	end

	wire is_subm  = (op_q == esso_pkg::OP_SUBM);
	wire is_swap  = (op_q == esso_pkg::OP_SWAP);
	wire is_swapa = (op_q == esso_pkg::OP_SWAPA);
	wire is_sz    = (op_q == esso_pkg::OP_SZ);
	wire is_sza   = (op_q == esso_pkg::OP_SZA);
	assign do_skip  = (is_sz | is_sza) & is_zero; // RULE7 RULE9
	wire   skip_now = in_exec & do_skip; // RULE7

	// memory write-back in the execute cycle only, never in the dummy cycle
	wire       mem_we_exec = in_exec & (is_subm | is_swap | is_sz); // RULE10
	wire [7:0] mem_wd_exec = is_subm ? diff : (is_swap ? swapped : mem_rdata); // RULE4 RULE6
	wire       apb_mem_we  = apb_wr & (paddr == esso_pkg::REG_MEM_DATA);

	// an accepted op starts its read at once; an idle memory follows the bus address
	wire [7:0] dm_addr  = idle ? (accept ? instr_addr : mem_addr_q) : addr_q;
	wire       dm_we    = mem_we_exec | apb_mem_we;
	wire [7:0] dm_wdata = mem_we_exec ? mem_wd_exec : pwdata[7:0];

	esso_dmem u_dmem (
		.pclk  (pclk),
		.ce    (ce),
		.addr  (dm_addr),
		.we    (dm_we),
		.wdata (dm_wdata),
		.rdata (mem_rdata)
	);

	// ==========================================================
	// accumulator and flags
	wire acc_from_op = in_exec & (is_swapa | is_sza);
	wire [7:0] acc_op_val = is_swapa ? swapped : mem_rdata; // RULE5 RULE9

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q   <= esso_pkg::ACC_RST;
			flags_q <= esso_pkg::FLAGS_RST;
		end else if (ce) begin
			if (acc_from_op) begin
				acc_q <= acc_op_val;
			end else if (wr_acc) begin
				acc_q <= pwdata[7:0];
			end
			if (in_exec && is_subm) begin
				flags_q <= sub_flags; // RULE3
			end else if (wr_flags) begin
				flags_q <= pwdata[5:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			op_q    <= esso_pkg::OP_NOP;
			addr_q  <= 8'h00;
			skip_q  <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			skip_q  <= skip_now;
			if (accept) begin
				op_q   <= instr_op;
				addr_q <= instr_addr;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q       <= esso_pkg::EN_RST;
			mem_addr_q <= esso_pkg::MADDR_RST;
		end else if (ce) begin
			if (wr_ctrl) begin
				en_q <= pwdata[0];
			end
			if (wr_maddr) begin
				mem_addr_q <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_cnt_q <= esso_pkg::SKIPS_RST;
		end else if (ce && skip_now) begin
			skip_cnt_q <= skip_cnt_q + 8'h01;
		end
	end

	// ==========================================================
	// apb read path
	// read data is taken in the setup cycle and holds through the access
	wire mapped = (paddr == esso_pkg::REG_CTRL) | (paddr == esso_pkg::REG_ACC)
		| (paddr == esso_pkg::REG_FLAGS) | (paddr == esso_pkg::REG_MEM_ADDR)
		| (paddr == esso_pkg::REG_MEM_DATA) | (paddr == esso_pkg::REG_STATUS);

	logic [31:0] rd_mux;
	always_comb begin
		case (paddr)
			esso_pkg::REG_CTRL:     rd_mux = {31'h0, en_q};
			esso_pkg::REG_ACC:      rd_mux = {24'h0, acc_q};
			esso_pkg::REG_FLAGS:    rd_mux = {26'h0, flags_q};
			esso_pkg::REG_MEM_ADDR: rd_mux = {24'h0, mem_addr_q};
			esso_pkg::REG_MEM_DATA: rd_mux = {24'h0, mem_rdata};
			esso_pkg::REG_STATUS:   rd_mux = {16'h0, skip_cnt_q, 7'h0, ~idle};
			default:                rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (ce && psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	assign pready      = ce & idle;
	assign pslverr     = apb_access & ~mapped;
	assign skip_taken  = skip_q;
	assign dummy_cycle = (state_q == ST_DUMMY); // RULE8 RULE10
	assign accumulator = acc_q;
	assign flags       = flags_q;
endmodule : esso_core

// ===== test/esso_monitor.sv
// assertions on the execution block ports
module esso_monitor (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// instruction side
	input wire logic       instr_valid,
	input wire logic [2:0] instr_op,
	input wire logic       instr_ready,
	input wire logic       skip_taken,
	input wire logic       dummy_cycle,
	input wire logic [7:0] accumulator,
	input wire logic [5:0] flags
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// accepted operation classes
	wire take = instr_valid & instr_ready;
	wire subm = take && instr_op == esso_pkg::OP_SUBM;
	wire keep = take && instr_op inside {[esso_pkg::OP_SWAP:esso_pkg::OP_SZA]};
	wire skop = take && instr_op inside {[esso_pkg::OP_SZ:esso_pkg::OP_SZA]};
	wire plain = take && instr_op inside {[esso_pkg::OP_SUBM:esso_pkg::OP_SWAPA]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// properties
	a_skip_pulse: assert property (skip_taken |=> !skip_taken) else $error("skip pulse");
	a_skip_cause: assert property ($rose(dummy_cycle) |-> $past(skop, 3))
		else $error("dummy without skip");
	a_dummy_quiet: assert property (dummy_cycle |=> $stable(flags) && $stable(accumulator))
		else $error("dummy changed state");
	a_flag_keep: assert property (keep |=> $stable(flags)[*3]) else $error("flags moved");
	a_subm_acc: assert property (subm |=> $stable(accumulator)[*3]) else $error("acc moved");
	a_plain_nodummy: assert property (plain |=> (!dummy_cycle)[*3]) else $error("bad dummy");
	a_copy_zero: assert property (skip_taken && $past(instr_op, 3) == esso_pkg::OP_SZA
		|-> accumulator == 8'h00) else $error("copy not zero");
	a_sub_zero: assert property ($past(subm, 3) && flags[esso_pkg::FLG_Z]
		|-> flags[esso_pkg::FLG_C] && flags[esso_pkg::FLG_CZ]) else $error("zero flags");
	c_skip: cover property (skip_taken);
	c_subm: cover property (subm);
	c_back: cover property (dummy_cycle ##1 take);
endmodule : esso_monitor
bind esso_core esso_monitor u_mon (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
	.instr_op(instr_op), .instr_ready(instr_ready), .skip_taken(skip_taken),
	.dummy_cycle(dummy_cycle), .accumulator(accumulator), .flags(flags));

// ===== test/tb.sv
// self-checking bench for the extended subtract, swap and skip block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
	logic        pready, pslverr, instr_ready, err, dmy_o, skp_o;
	logic [1:0]  nd;
	logic [2:0]  instr_op = 0, o;
	logic [7:0]  paddr = 0, instr_addr = 0, m, c, ea, em, sk = 0, acc_o;
	logic [5:0]  f, ef, flg_o;
	logic [31:0] pwdata = 0, prdata, r;
	int          seed = 32'h123f8cea, n_mismatch = 0, n_compared = 0;
	esso_core uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_addr(instr_addr), .instr_ready(instr_ready), .skip_taken(skp_o),
		.dummy_cycle(dmy_o), .accumulator(acc_o), .flags(flg_o));
	// ==========================================================
	// tasks
	task chk(input string s, input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk iff pready);
		r = prdata;
		err = pslverr;
		psel    <= 0;
		penable <= 0;
	endtask : apb
	task op(input logic [2:0] x, input logic [7:0] a);
		@(posedge pclk);
		instr_valid <= 1;
		instr_op    <= x;
		instr_addr  <= a;
		@(posedge pclk iff instr_ready);
		instr_valid <= 0;
		nd = 0;
		repeat (3) begin
			@(negedge pclk);
			nd += {1'b0, dmy_o} + {1'b0, skp_o};
		end
		@(posedge pclk);
	endtask : op
	function automatic logic [5:0] subf(input logic [7:0] a, b);
		logic [7:0] d;
		logic       v;
		d = a - b;
		v = (a[7] ^ b[7]) & (d[7] ^ a[7]);
		return {d == 0, ~(v ^ d[7]), v, d == 0, a[3:0] >= b[3:0], a >= b};
	endfunction : subf
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// ==========================================================
	// clock, watchdog and sequence
	initial begin
		forever #50 pclk = ~pclk;
	end
	initial begin
		#1000000;
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h18, 0);
		chk("unmapped", {err, r[30:0]}, 32'h80000000);
		apb(0, esso_pkg::REG_CTRL, 0);
		chk("enable", r, 32'(esso_pkg::EN_RST));
		apb(1, esso_pkg::REG_CTRL, 0);
		instr_valid <= 1;
		instr_op    <= esso_pkg::OP_SZA;
		repeat (4) begin
			@(negedge pclk);
			chk("disabled", instr_ready, 0);
		end
		@(posedge pclk);
		instr_valid <= 0;
		apb(1, esso_pkg::REG_CTRL, 1);
		for (int i = 0; i < 40; i++) begin
			o = 3'(i % 5 + 1);
			m = (i % 4 == 3) ? 8'h00 : 8'($random(seed));
			c = (i == 5) ? m : 8'($random(seed));
			f = 6'($random(seed));
			apb(1, esso_pkg::REG_MEM_ADDR, i);
			apb(1, esso_pkg::REG_MEM_DATA, m);
			apb(1, esso_pkg::REG_ACC, c);
			apb(1, esso_pkg::REG_FLAGS, f);
			op(o, 8'(i));
			ea = c;
			em = m;
			ef = f;
			case (o)
				1: begin
					em = c - m;
					ef = subf(c, m);
				end
				2: em = {m[3:0], m[7:4]};
				3: ea = {m[3:0], m[7:4]};
				5: ea = m;
				default: ;
			endcase
			if (o > 3 && m == 0) sk++;
			apb(0, esso_pkg::REG_ACC, 0);
			chk("acc", r, ea);
			apb(0, esso_pkg::REG_MEM_DATA, 0);
			chk("mem", r, em);
			apb(0, esso_pkg::REG_FLAGS, 0);
			chk("flags", r, ef);
			apb(0, esso_pkg::REG_STATUS, 0);
			chk("skips", r, {sk, 8'h00});
			chk("dummy", nd, (o > 3 && m == 0) ? 2 : 0);
			chk("acc port", acc_o, ea);
			chk("flag port", flg_o, ef);
			$display("test %0d op %0d done", i, o);
		end
		finish_test;
	end
endmodule : tb
